// File: include/stc_pkg.sv
// Constants shared by the sync timer connection block.
// Assumes one 25 MHz system clock and a plain 8-bit register port.
package stc_pkg;
   // Register offsets on the plain register port
   localparam logic [3:0] A_EDGE    = 4'h0;
   localparam logic [3:0] A_CTRL    = 4'h1;
   localparam logic [3:0] A_AUX_CFG = 4'h2;
   localparam logic [3:0] A_AUX_CMA = 4'h3;
   localparam logic [3:0] A_AUX_CMB = 4'h4;
   localparam logic [3:0] A_T1_CFG  = 4'h5;
   localparam logic [3:0] A_T1_OS   = 4'h6;
   localparam logic [3:0] A_T1_CMA  = 4'h7;
   localparam logic [3:0] A_FRT_CFG = 4'h8;
   localparam logic [3:0] A_CAP_LO  = 4'h9;
   localparam logic [3:0] A_CAP_HI  = 4'hA;
   localparam logic [3:0] A_IRQ_ST  = 4'hB;
   localparam logic [3:0] A_IRQ_MSK = 4'hC;
   localparam logic [3:0] A_AUX_CNT = 4'hD;
   localparam logic [3:0] A_STATUS  = 4'hE;
   // Edge flag register layout and reset value
   localparam logic [7:0] EDGE_RST  = 8'h0F;
   localparam logic [3:0] EDGE_RSV  = 4'hF;
   // Input index into the sense vector
   localparam int IN_V   = 0;
   localparam int IN_H   = 1;
   localparam int IN_C   = 2;
   localparam int IN_F   = 3;
   localparam int IN_CAP = 4;
   localparam int IN_T1C = 5;
   localparam int IN_T1R = 6;
   localparam int IN_NUM = 7;
   // Control register fields
   localparam int C_OE   = 0;
   localparam int C_CLM  = 1;
   localparam int C_RT0  = 2;
   // Timer configuration encodings
   localparam logic [2:0] CKS_INT  = 3'h1;
   localparam logic [2:0] CKS_EXT  = 3'h5;
   localparam logic [1:0] CLR_EXT  = 2'h3;
   localparam logic [1:0] FCK_DIV2 = 2'h0;
   localparam logic [3:0] OS_TOG_A = 4'h3;
   // Capture source routing modes
   localparam logic [1:0] RT_PIN  = 2'h0;
   localparam logic [1:0] RT_VERT = 2'h1;
   localparam logic [1:0] RT_HORZ = 2'h2;
   localparam logic [1:0] RT_DIV  = 2'h3;
   // Interrupt status layout: four edges then capture
   localparam int IRQ_W   = 5;
   localparam int IRQ_CAP = 4;
   // Free-running timer prescale
   localparam int FRT_DIV = 2;
endpackage : stc_pkg

// File: src/stc_edge_sense.sv
// Synchroniser and edge finder for a vector of sync input pins.
// Assumes all pins may change at any time relative to mclk.
`timescale 1ns/1ps
module stc_edge_sense #(
   parameter int N = 7
) (
   input  wire logic         mclk,
   input  wire logic         resetn,
   input  wire logic [N-1:0] pins,
   output logic      [N-1:0] level,
   output logic      [N-1:0] rise,
   output logic      [N-1:0] fall
);
   logic [N-1:0] meta_r;
   logic [N-1:0] prev_r;

   if (N < 1) begin : g_chk
      $error("stc_edge_sense needs at least one input");
   end

   // Two-stage synchroniser, then last sampled level
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         meta_r <= '0;
         level  <= '0;
         prev_r <= '0;
      end else begin
         meta_r <= pins;
         level  <= meta_r;
         prev_r <= level;
      end
   end

   // Compare with previous sampled level
   assign rise = level & ~prev_r;
   assign fall = ~level & prev_r;
endmodule : stc_edge_sense

// File: src/stc_top.sv
// Sync timer connection: edge flags, pulse decoder, clamps, timers.
// Assumes a master that holds strobes one cycle and never waits.
`timescale 1ns/1ps
module stc_top (
   input  wire logic       mclk,
   input  wire logic       resetn,
   input  wire logic       standby,
   input  wire logic [3:0] addr,
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_data,
   input  wire logic       rd_en,
   output logic      [7:0] rd_data,
   input  wire logic       vertical_sync_in_pin,
   input  wire logic       horizontal_sync_in_pin,
   input  wire logic       composite_sync_in_pin,
   input  wire logic       feedback_in_pin,
   input  wire logic       capture_pin,
   input  wire logic       t1_clock_pin,
   input  wire logic       t1_reset_pin,
   output logic            irq,
   output logic            decoded_pulse_out,
   output logic            clamp_out_pin,
   output logic            clamp_out_en,
   output logic            timer_one_out
);
   localparam int NI = stc_pkg::IN_NUM;
   localparam int IRQ_W_L = stc_pkg::IRQ_W;

   logic [NI-1:0] lvl;
   logic [NI-1:0] rise;
   logic [NI-1:0] fall;
   logic [3:0]    flags_r;   // bit 3 is vertical, bit 0 feedback
   logic [3:0]    armed_r;
   logic [3:0]    flag_clr;
   logic [7:0]    ctrl_r;
   logic [7:0]    aux_cfg_r;
   logic [7:0]    compare_value_a;
   logic [7:0]    compare_value_b;
   logic [7:0]    t1_cfg_r;
   logic [3:0]    output_action_select;
   logic [7:0]    compare_value;
   logic [2:0]    frt_cfg_r;
   logic [7:0]    aux_cnt_r;
   logic [7:0]    aux_cnt_nxt;
   logic [7:0]    t1_cnt_r;
   logic [7:0]    t1_cnt_nxt;
   logic [15:0]   free_running_count;
   logic [15:0]   capture_register;
   logic          pre_r;
   logic          cap_src;
   logic          cap_prev_r;
   logic          cap_evt;
   logic          match_a;
   logic          match_b;
   logic          match_t1;
   logic          internal_horizontal_sync;
   logic          ihi_rise;
   logic          ihi_fall;
   logic          iv_rise;
   logic          clamp_wave_one;
   logic          clamp_wave_two;
   logic [IRQ_W_L-1:0] irq_st_r;
   logic [IRQ_W_L-1:0] irq_msk_r;
   logic [IRQ_W_L-1:0] irq_evt;
   logic [IRQ_W_L-1:0] irq_clr;
   logic [1:0]    route;
   logic          wr_edge;
   logic [7:0]    rd_nxt;

   // True when a counter stepped onto the compare value
   function automatic logic stc_match(input logic [7:0] cur,
                                      input logic [7:0] nxt,
                                      input logic [7:0] cmp);
      stc_match = (cur != nxt) && (nxt == cmp);
   endfunction : stc_match

   stc_edge_sense #(.N(NI)) u_sense (
      .mclk   (mclk),
      .resetn (resetn),
      .pins   ({t1_reset_pin, t1_clock_pin, capture_pin,
                feedback_in_pin, composite_sync_in_pin,
                horizontal_sync_in_pin, vertical_sync_in_pin}),
      .level  (lvl),
      .rise   (rise),
      .fall   (fall)
   );

   // Internal sync signals come straight from the synchronised pins
   assign internal_horizontal_sync      = lvl[stc_pkg::IN_H];
   assign ihi_rise = rise[stc_pkg::IN_H];
   assign ihi_fall = fall[stc_pkg::IN_H];
   assign iv_rise  = rise[stc_pkg::IN_V];
   assign route    = ctrl_r[stc_pkg::C_RT0 +: 2];
   assign wr_edge  = wr_en && (addr == stc_pkg::A_EDGE);

   // Clear only flags seen as one by an earlier read and written zero
   assign flag_clr = wr_edge ? (armed_r & ~wr_data[7:4]) : 4'h0;

   // Edge flags: set by rises, set wins over clear
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         flags_r <= stc_pkg::EDGE_RST[7:4];
      end else if (standby) begin
         flags_r <= stc_pkg::EDGE_RST[7:4];
      end else begin
         flags_r[3] <= rise[stc_pkg::IN_V] |
                       (flags_r[3] & ~flag_clr[3]);
         flags_r[2] <= rise[stc_pkg::IN_H] |
                       (flags_r[2] & ~flag_clr[2]);
         flags_r[1] <= rise[stc_pkg::IN_C] |
                       (flags_r[1] & ~flag_clr[1]);
         flags_r[0] <= rise[stc_pkg::IN_F] |
                       (flags_r[0] & ~flag_clr[0]);
      end
   end

   // Remember which flags a read found set; a write to the edge register or standby disarms
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         armed_r <= 4'h0;
      end else if (standby || wr_edge) begin
         armed_r <= 4'h0;
      end else if (rd_en && (addr == stc_pkg::A_EDGE)) begin
         armed_r <= armed_r | flags_r;
      end
   end

   // Configuration registers
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ctrl_r               <= 8'h00;
         aux_cfg_r            <= 8'h00;
         compare_value_a      <= 8'hFF;
         compare_value_b      <= 8'hFF;
         t1_cfg_r             <= 8'h00;
         output_action_select <= 4'h0;
         compare_value        <= 8'hFF;
         frt_cfg_r            <= 3'h0;
         irq_msk_r            <= '0;
      end else if (wr_en) begin
         case (addr)
            stc_pkg::A_CTRL:    ctrl_r <= wr_data;
            stc_pkg::A_AUX_CFG: aux_cfg_r <= wr_data;
            stc_pkg::A_AUX_CMA: compare_value_a <= wr_data;
            stc_pkg::A_AUX_CMB: compare_value_b <= wr_data;
            stc_pkg::A_T1_CFG:  t1_cfg_r <= wr_data;
            stc_pkg::A_T1_OS:   output_action_select <= wr_data[3:0];
            stc_pkg::A_T1_CMA:  compare_value <= wr_data;
            stc_pkg::A_FRT_CFG: frt_cfg_r <= wr_data[2:0];
            stc_pkg::A_IRQ_MSK: irq_msk_r <= wr_data[IRQ_W_L-1:0];
            default: ;
         endcase
      end
   end

   // Auxiliary timer: clear on sync rise, count on internal clock
   always_comb begin
      aux_cnt_nxt = aux_cnt_r;
      if (ihi_rise && (aux_cfg_r[4:3] == stc_pkg::CLR_EXT)) begin
         aux_cnt_nxt = 8'h00;
      end else if (aux_cfg_r[2:0] == stc_pkg::CKS_INT) begin
         aux_cnt_nxt = aux_cnt_r + 8'h01;
      end
   end

   assign match_a = stc_match(aux_cnt_r, aux_cnt_nxt, compare_value_a);
   assign match_b = stc_match(aux_cnt_r, aux_cnt_nxt, compare_value_b);

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         aux_cnt_r <= 8'h00;
      end else begin
         aux_cnt_r <= aux_cnt_nxt;
      end
   end

   // Delay latch: sync level sampled at compare B
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         decoded_pulse_out <= 1'b0;
      end else if (match_b) begin
         decoded_pulse_out <= internal_horizontal_sync;
      end
   end

   // Clamp waves: edges of sync set them, compare A ends them
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         clamp_wave_one <= 1'b0;
         clamp_wave_two <= 1'b0;
      end else begin
         if (ihi_rise) begin
            clamp_wave_one <= 1'b1;
         end else if (match_a) begin
            clamp_wave_one <= 1'b0;
         end
         if (ihi_fall) begin
            clamp_wave_two <= 1'b1;
         end else if (match_a) begin
            clamp_wave_two <= 1'b0;
         end
      end
   end

   // Clamp pin selection
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         clamp_out_pin <= 1'b0;
         clamp_out_en  <= 1'b0;
      end else begin
         clamp_out_en  <= ctrl_r[stc_pkg::C_OE];
         clamp_out_pin <= ctrl_r[stc_pkg::C_CLM] ? clamp_wave_two
                                                 : clamp_wave_one;
      end
   end

   // Timer one: clock and reset come from sync signals when routed
   always_comb begin
      logic clk_rise;
      logic rst_rise;
      clk_rise = (route == stc_pkg::RT_PIN) ?
                 rise[stc_pkg::IN_T1C] : ihi_rise;
      rst_rise = (route == stc_pkg::RT_PIN) ?
                 rise[stc_pkg::IN_T1R] : iv_rise;
      t1_cnt_nxt = t1_cnt_r;
      if (rst_rise && (t1_cfg_r[4:3] == stc_pkg::CLR_EXT)) begin
         t1_cnt_nxt = 8'h00;
      end else if (clk_rise &&
                   (t1_cfg_r[2:0] == stc_pkg::CKS_EXT)) begin
         t1_cnt_nxt = t1_cnt_r + 8'h01;
      end
   end

   assign match_t1 = stc_match(t1_cnt_r, t1_cnt_nxt, compare_value);

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         t1_cnt_r <= 8'h00;
      end else begin
         t1_cnt_r <= t1_cnt_nxt;
      end
   end

   // Timer one output: compare A action, compare B not used
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         timer_one_out <= 1'b0;
      end else if (match_t1) begin
         case (output_action_select[1:0])
            2'h1:    timer_one_out <= 1'b0;
            2'h2:    timer_one_out <= 1'b1;
            2'h3:    timer_one_out <= ~timer_one_out;
            default: timer_one_out <= timer_one_out;
         endcase
      end
   end

   // Capture source routing
   always_comb begin
      case (route)
         stc_pkg::RT_PIN:  cap_src = lvl[stc_pkg::IN_CAP];
         stc_pkg::RT_VERT: cap_src = lvl[stc_pkg::IN_V];
         stc_pkg::RT_HORZ: cap_src = internal_horizontal_sync;
         stc_pkg::RT_DIV:  cap_src = timer_one_out;
         default:          cap_src = 1'b0;
      endcase
   end

   // Edge select bit chooses rising or falling capture
   assign cap_evt = frt_cfg_r[0] ? (cap_src & ~cap_prev_r)
                                 : (~cap_src & cap_prev_r);

   // Free-running count at half rate, capture on selected edge
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pre_r              <= 1'b0;
         cap_prev_r         <= 1'b0;
         free_running_count <= 16'h0000;
         capture_register   <= 16'h0000;
      end else begin
         pre_r      <= ~pre_r;
         cap_prev_r <= cap_src;
         if (pre_r && (frt_cfg_r[2:1] == stc_pkg::FCK_DIV2)) begin
            free_running_count <= free_running_count + 16'h0001;
         end
         if (cap_evt) begin
            capture_register <= free_running_count;
         end
      end
   end

   // Interrupt status: sticky, cleared by reading, set wins
   assign irq_evt = {cap_evt, rise[stc_pkg::IN_V], rise[stc_pkg::IN_H],
                     rise[stc_pkg::IN_C], rise[stc_pkg::IN_F]};
   assign irq_clr = (rd_en && (addr == stc_pkg::A_IRQ_ST)) ?
                    irq_st_r : '0;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         irq_st_r <= '0;
         irq      <= 1'b0;
      end else begin
         irq_st_r <= irq_evt | (irq_st_r & ~irq_clr);
         irq      <= |((irq_evt | (irq_st_r & ~irq_clr)) & irq_msk_r);
      end
   end

   // Read data selection
   always_comb begin
      case (addr)
         stc_pkg::A_EDGE:    rd_nxt = {flags_r, stc_pkg::EDGE_RSV};
         stc_pkg::A_CTRL:    rd_nxt = ctrl_r;
         stc_pkg::A_AUX_CFG: rd_nxt = aux_cfg_r;
         stc_pkg::A_AUX_CMA: rd_nxt = compare_value_a;
         stc_pkg::A_AUX_CMB: rd_nxt = compare_value_b;
         stc_pkg::A_T1_CFG:  rd_nxt = t1_cfg_r;
         stc_pkg::A_T1_OS:   rd_nxt = {4'h0, output_action_select};
         stc_pkg::A_T1_CMA:  rd_nxt = compare_value;
         stc_pkg::A_FRT_CFG: rd_nxt = {5'h00, frt_cfg_r};
         stc_pkg::A_CAP_LO:  rd_nxt = capture_register[7:0];
         stc_pkg::A_CAP_HI:  rd_nxt = capture_register[15:8];
         stc_pkg::A_IRQ_ST:  rd_nxt = {3'h0, irq_st_r};
         stc_pkg::A_IRQ_MSK: rd_nxt = {3'h0, irq_msk_r};
         stc_pkg::A_AUX_CNT: rd_nxt = aux_cnt_r;
         stc_pkg::A_STATUS:  rd_nxt = {4'h0, timer_one_out,
                                       clamp_wave_two, clamp_wave_one,
                                       decoded_pulse_out};
         default:            rd_nxt = 8'h00;
      endcase
   end

   // Read data stand one cycle after the strobe
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rd_data <= 8'h00;
      end else if (rd_en) begin
         rd_data <= rd_nxt;
      end else begin
         rd_data <= 8'h00;
      end
   end

   // Checks on the logic above
   rsv_read_a: assert property (@(posedge mclk) disable iff (!resetn)
      rd_en && addr == stc_pkg::A_EDGE |=> rd_data[3:0] == 4'hF)
      else $error("reserved edge bits not one");
   vert_set_a: assert property (@(posedge mclk) disable iff (!resetn)
      !standby && $rose(lvl[stc_pkg::IN_V]) |-> ##1 flags_r[3])
      else $error("vertical flag not set");
   horz_set_a: assert property (@(posedge mclk) disable iff (!resetn)
      !standby && rise[stc_pkg::IN_H] |=> flags_r[2])
      else $error("horizontal flag not set");
   comp_set_a: assert property (@(posedge mclk) disable iff (!resetn)
      !standby && rise[stc_pkg::IN_C] |=> flags_r[1])
      else $error("composite flag not set");
   fb_set_a: assert property (@(posedge mclk) disable iff (!resetn)
      !standby && rise[stc_pkg::IN_F] |=> flags_r[0])
      else $error("feedback flag not set");
   no_blind_clr_a: assert property (@(posedge mclk)
      disable iff (!resetn)
      wr_edge && armed_r == 4'h0 && !standby |=>
      flags_r == ($past(flags_r) |
                  $past({rise[stc_pkg::IN_V], rise[stc_pkg::IN_H],
                         rise[stc_pkg::IN_C], rise[stc_pkg::IN_F]})))
      else $error("flag cleared without prior read");
   set_wins_a: assert property (@(posedge mclk) disable iff (!resetn)
      !standby && rise[stc_pkg::IN_V] && flag_clr[3] |=> flags_r[3])
      else $error("edge lost on clear");
   pdc_latch_a: assert property (@(posedge mclk) disable iff (!resetn)
      match_b |=> decoded_pulse_out == $past(internal_horizontal_sync))
      else $error("decoded output not latched");
   clamp_rise_a: assert property (@(posedge mclk) disable iff (!resetn)
      ihi_fall |=> clamp_wave_two ##0 $past(internal_horizontal_sync, 2))
      else $error("clamp two did not rise");
   clamp_fall_a: assert property (@(posedge mclk) disable iff (!resetn)
      match_a && !ihi_rise && !ihi_fall |=>
      !clamp_wave_one && !clamp_wave_two)
      else $error("clamps did not fall");
   t1_toggle_a: assert property (@(posedge mclk) disable iff (!resetn)
      match_t1 && output_action_select == stc_pkg::OS_TOG_A |=>
      timer_one_out != $past(timer_one_out))
      else $error("timer one did not toggle");
   capture_a: assert property (@(posedge mclk) disable iff (!resetn)
      cap_evt |=> capture_register == $past(free_running_count))
      else $error("capture missed count");
   div_route_a: assert property (@(posedge mclk) disable iff (!resetn)
      route == stc_pkg::RT_DIV && $stable(route) && frt_cfg_r[0] &&
      $rose(timer_one_out) |=>
      capture_register == $past(free_running_count))
      else $error("capture not routed from timer one");
   clamp_pin_a: assert property (@(posedge mclk) disable iff (!resetn)
      ctrl_r[stc_pkg::C_OE] && !ctrl_r[stc_pkg::C_CLM] ##1
      $stable(ctrl_r) |-> clamp_out_en &&
      clamp_out_pin == $past(clamp_wave_one))
      else $error("clamp pin wrong wave");
endmodule : stc_top

// File: tb/stc_sync_src.sv
// Model of the external sync and feedback signal sources.
// Assumes the bench asks for one pulse at a time, timed on mclk.
`timescale 1ns/1ps
module stc_sync_src (
   input  wire logic mclk,
   output logic      vsync,
   output logic      hsync,
   output logic      csync,
   output logic      fback
);
   logic [3:0] lvl_r = 4'h0;
   // Pin order: vertical, horizontal, composite, feedback
   assign vsync = lvl_r[0];
   assign hsync = lvl_r[1];
   assign csync = lvl_r[2];
   assign fback = lvl_r[3];
   // Pulse hi cycles high then lo low; hi of one or more, else unseen
   task pulse(input int idx, input int hi, input int lo);
      @(posedge mclk);
      lvl_r[idx] <= 1'b1;
      repeat (hi) @(posedge mclk);
      lvl_r[idx] <= 1'b0;
      repeat (lo) @(posedge mclk);
   endtask : pulse
endmodule : stc_sync_src

// File: tb/testbench.sv
// Self-checking bench for the sync timer connection block.
// Assumes the sync source model; capture and timer pins held low.
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin \
   miscompares++; $display("wrong value %s exp %h got %h", nm, e, a); \
   end end
module testbench;
   logic        mclk, resetn, standby, wr_en, rd_en, irq, dec, clo, cle;
   logic        t1o, vs, hs, cs, fb, ok;
   logic [3:0]  addr;
   logic [7:0]  wr_data, rd_data, d;
   logic [15:0] cap_a, cap_b;
   int          miscompares, n_compared, e, g;
   time         t_a, t_b;
   stc_top u_dut (.mclk(mclk), .resetn(resetn), .standby(standby),
      .addr(addr), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en),
      .rd_data(rd_data), .vertical_sync_in_pin(vs),
      .horizontal_sync_in_pin(hs), .composite_sync_in_pin(cs),
      .feedback_in_pin(fb), .capture_pin(1'b0), .t1_clock_pin(1'b0),
      .t1_reset_pin(1'b0), .irq(irq), .decoded_pulse_out(dec),
      .clamp_out_pin(clo), .clamp_out_en(cle), .timer_one_out(t1o));
   stc_sync_src src (.mclk(mclk), .vsync(vs), .hsync(hs), .csync(cs),
      .fback(fb));
   // 25 MHz clock
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // Register port accesses, one strobe cycle each
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge mclk);
      addr    <= a;
      wr_data <= v;
      wr_en   <= 1'b1;
      @(posedge mclk);
      wr_en   <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge mclk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge mclk);
      rd_en <= 1'b0;
      #1 d = rd_data;
   endtask : rd
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask : done
   task automatic end_sim();
      $display("compared %0d, wrong %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_sim
   // Bounded wait for the timer one output to reach a level
   task automatic wait_t1(input logic v, output time t);
      for (int k = 0; k < 40; k++) begin
         cyc(1);
         if (t1o === v) begin
            t = $time;
            return;
         end
      end
      miscompares++;
      $display("wrong value timer one wait exp %h got %h", v, t1o);
      end_sim();
   endtask : wait_t1
   task automatic rdcap(output logic [15:0] c);
      rd(stc_pkg::A_CAP_LO);
      c[7:0] = d;
      rd(stc_pkg::A_CAP_HI);
      c[15:8] = d;
   endtask : rdcap
   // Reset value, refused writes, masking, standby, unmapped read
   task automatic t_misc();
      rd(stc_pkg::A_EDGE);
      `CHK("edge reset", 8'h0F, d)
      cyc(1);
      `CHK("read idle", 8'h00, rd_data)
      wr(stc_pkg::A_EDGE, 8'hF0);
      rd(stc_pkg::A_EDGE);
      `CHK("edge write one", 8'h0F, d)
      src.pulse(0, 2, 4);
      cyc(0);
      `CHK("irq masked", 1'b0, irq)
      wr(stc_pkg::A_EDGE, 8'h00);
      rd(stc_pkg::A_EDGE);
      `CHK("clear unarmed", 8'h8F, d)
      wr(stc_pkg::A_IRQ_MSK, 8'h08);
      cyc(2);
      `CHK("irq unmasked", 1'b1, irq)
      rd(stc_pkg::A_IRQ_ST);
      `CHK("irq status", 8'h08, d)
      cyc(2);
      `CHK("irq read clear", 1'b0, irq)
      wr(stc_pkg::A_EDGE, 8'h00);
      rd(stc_pkg::A_EDGE);
      `CHK("clear armed", 8'h0F, d)
      src.pulse(3, 2, 4);
      standby <= 1'b1;
      cyc(2);
      rd(stc_pkg::A_EDGE);
      `CHK("edge standby", 8'h0F, d)
      @(posedge mclk);
      standby <= 1'b0;
      rd(4'hF);
      `CHK("unmapped read", 8'h00, d)
      done("misc");
   endtask : t_misc
   // Each pin rise sets its own flag and status bit
   task automatic t_edges();
      rd(stc_pkg::A_IRQ_ST);
      `CHK("irq stale", 8'h01, d)
      wr(stc_pkg::A_IRQ_MSK, 8'h0F);
      for (int i = 0; i < 4; i++) begin
         src.pulse(i, 2, 4);
         rd(stc_pkg::A_EDGE);
         `CHK("edge flag", 8'h0F | (8'h80 >> i), d)
         `CHK("irq set", 1'b1, irq)
         rd(stc_pkg::A_IRQ_ST);
         `CHK("irq bit", 8'h08 >> i, d)
         cyc(1);
         `CHK("irq clear", 1'b0, irq)
         wr(stc_pkg::A_EDGE, 8'h00);
         rd(stc_pkg::A_EDGE);
         `CHK("edge clear", 8'h0F, d)
      end
      done("edges");
   endtask : t_edges
   // Clamp edges, clamp pin select and pulse width decoding
   task automatic t_clamp(input logic mode);
      wr(stc_pkg::A_CTRL, {6'h00, mode, 1'b1});
      wr(stc_pkg::A_AUX_CFG, 8'h19);
      wr(stc_pkg::A_AUX_CMA, 8'h08);
      wr(stc_pkg::A_AUX_CMB, 8'h07);
      fork
         src.pulse(1, 20, 40);
         begin
            cyc(8);
            `CHK("clamp early", ~mode, clo)
            cyc(10);
            `CHK("clamp matched", 1'b0, clo)
            cyc(12);
            `CHK("clamp late", mode, clo)
         end
      join
      cyc(0);
      `CHK("clamp enable", 1'b1, cle)
      `CHK("decode wide", 1'b1, dec)
      src.pulse(1, 3, 40);
      cyc(0);
      `CHK("decode narrow", 1'b0, dec)
      done("clamp");
   endtask : t_clamp
   // Divided horizontal waveform measured by the capture timer
   task automatic t_timer();
      wr(stc_pkg::A_CTRL, 8'h0D);
      wr(stc_pkg::A_T1_CFG, 8'h1D);
      wr(stc_pkg::A_T1_OS, 8'h03);
      wr(stc_pkg::A_T1_CMA, 8'h02);
      wr(stc_pkg::A_FRT_CFG, 8'h01);
      src.pulse(0, 2, 4);
      src.pulse(1, 2, 4);
      cyc(2);
      `CHK("timer one early", 1'b0, t1o)
      fork
         src.pulse(1, 2, 4);
         wait_t1(1'b1, t_a);
      join
      rdcap(cap_a);
      src.pulse(0, 2, 4);
      src.pulse(1, 2, 4);
      fork
         src.pulse(1, 2, 4);
         wait_t1(1'b0, t_b);
      join
      src.pulse(0, 2, 4);
      src.pulse(1, 2, 4);
      fork
         src.pulse(1, 2, 4);
         wait_t1(1'b1, t_b);
      join
      rdcap(cap_b);
      e = int'((t_b - t_a) / 80);
      g = int'(cap_b - cap_a);
      ok = (g >= e - 1) && (g <= e + 1);
      `CHK("capture span", 1'b1, ok)
      done("timer");
   endtask : t_timer
   // Reset, then the scenarios in order
   initial begin
      resetn  = 1'b0;
      standby = 1'b0;
      wr_en   = 1'b0;
      rd_en   = 1'b0;
      addr    = 4'h0;
      wr_data = 8'h00;
      repeat (16) @(posedge mclk);
      resetn <= 1'b1;
      t_misc();
      t_edges();
      t_clamp(1'b0);
      t_clamp(1'b1);
      t_clamp(1'b0);
      t_timer();
      end_sim();
   end
endmodule : testbench
